// ---- inc/cglc_pkg.sv ----
// Shared constants and types of the counter gate, latch and compare block
package cglc_pkg;
   // Register byte offsets
   localparam logic [5:0] ADDR_CTRL   = 6'h00;
   localparam logic [5:0] ADDR_CFG    = 6'h04;
   localparam logic [5:0] ADDR_LOAD   = 6'h08;
   localparam logic [5:0] ADDR_END    = 6'h0c;
   localparam logic [5:0] ADDR_COMP   = 6'h10;
   localparam logic [5:0] ADDR_PARAM  = 6'h14;
   localparam logic [5:0] ADDR_STATUS = 6'h18;
   localparam logic [5:0] ADDR_DATA   = 6'h1c;
   localparam int         ADDR_W      = 6;
   // Output status word bits
   localparam int CTRL_DOUT      = 0;
   localparam int CTRL_SW_OPEN   = 2;
   localparam int CTRL_LATCH_SEL = 8;
   localparam int CTRL_SW_CLOSE  = 10;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0505;
   // Configuration fields
   localparam int CFG_GATE_LSB = 0;
   localparam int CFG_GATE_W   = 5;
   localparam int GATE_HW_BIT  = 0;
   localparam int GATE_INT_BIT = 4;
   localparam int CFG_MODE_LSB = 5;
   localparam int CFG_DIR_LSB  = 7;
   localparam int CFG_ONCE     = 9;
   localparam int CFG_IRQ_EN   = 10;
   localparam logic [31:0] CFG_MASK = 32'h0000_07ff;
   // Parameter word fields
   localparam int PAR_DUR_LSB  = 0;
   localparam int PAR_HYST_LSB = 8;
   localparam int PAR_FIELD_W  = 8;
   localparam logic [31:0] PARAM_MASK = 32'h0000_ffff;
   // Input status word bits
   localparam int STS_IGATE     = 0;
   localparam int STS_SWGATE    = 1;
   localparam int STS_HWGATE    = 2;
   localparam int STS_OUT       = 3;
   localparam int STS_HYST      = 4;
   localparam int STS_PULSE     = 5;
   localparam int STS_LATCH_NEW = 15;
   // Counter limits and reset values
   localparam logic signed [31:0] CNT_MAX = 32'sh7fff_ffff;
   localparam logic signed [31:0] CNT_MIN = 32'sh8000_0000;
   localparam logic signed [31:0] CNT_ONE = 32'sh0000_0001;
   localparam logic [31:0]        RST_ZERO = 32'h0000_0000;
   localparam logic [7:0]         HYST_OFF_MAX = 8'h01;
   // Pulse timing
   localparam real PULSE_STEP_MS = 2.048;
   localparam real PULSE_MAX_MS  = 522.24;
   localparam real CLK_MHZ       = 250.0;
   localparam int  PULSE_STEP_CYC = int'(PULSE_STEP_MS * 1000.0 * CLK_MHZ);
   localparam int  PULSE_MAX_STEPS = int'(PULSE_MAX_MS / PULSE_STEP_MS);
   typedef enum logic [1:0] {CMP_NEVER, CMP_GE, CMP_PULSE, CMP_RSVD} cglc_cmp_mode_t;
   typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN, DIR_RSVD} cglc_dir_t;
endpackage : cglc_pkg

// ---- inc/cglc_pin_if.sv ----
// Carrier between a raw input pin and its synchroniser
`timescale 1ns/10ps
interface cglc_pin_if;
   logic raw;
   logic level;
   logic rise;
   modport sync (input raw, output level, output rise);
   modport user (output raw, input level, input rise);
endinterface : cglc_pin_if

// ---- design/cglc_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising-edge detect
`timescale 1ns/10ps
module cglc_pin_sync (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   cglc_pin_if.sync  pin
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   wire  agree = (s2_q == s3_q);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            level_q <= s3_q;
         end
      end
   end

   assign pin.level = level_q;
   assign pin.rise  = agree && s3_q && !level_q;
endmodule : cglc_pin_sync

// ---- design/cglc_top.sv ----
// Counter channel with gate control, latch, comparison output and hysteresis
// Notes on behaviour
// - Rising output status bit 2 opens the software gate.
// - Rising output status bit 10 closes the software gate.
// - Hardware gate follows gate pin unless disabled; then software gate alone enables.
// - Hardware rise takes software level; software rise opens only if hardware high/off.
// - Abort behaviour reloads the load value when the gate reopens, except on a software rise in combined mode.
// - Interrupt behaviour resumes from the held count when the gate reopens.
// - Five-bit gate field: bit0 hardware gate on, bit4 interrupt instead of abort.
// - Combined mode: software rise continues; hardware rise restarts (abort) or continues.
// - Count once after auto close: with hardware gate on, reopen needs hardware rise first.
// - Latch pin rise during counting copies the count into the latch register.
// - Output status bit 8 shows the latch value in the data word.
// - Input status bit 15 sets on new latch, clears when bit 8 rises.
// - Comparison drives the channel output and an optional event pulse.
// - Never-switch mode: output follows the program-driven bit.
// - Greater-or-equal mode: output high while count at or above comparison.
// - Pulse mode zero duration holds while equal; main direction must match.
// - Pulse length 0 to 522.24 ms in 2.048 ms steps, from output set.
// - A running pulse is never retriggered or extended.
// - Hysteresis width 0 to 255; 0 and 1 turn it off.
// - Hysteresis suppresses repeated toggles and events near the threshold.
// - A width change leaves an active band alone; applies at next event.
// - Result frozen inside the band; new band only when condition met again.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
module cglc_top #(
   parameter int STEP_CYCLES = cglc_pkg::PULSE_STEP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        cnt_up,
   input  wire logic        cnt_down,
   input  wire logic        gate_pin,
   input  wire logic        latch_pin,
   output logic             cnt_out,
   output logic             cmp_event
);
   cglc_pin_if gate_if ();
   cglc_pin_if latch_if ();
   assign gate_if.raw  = gate_pin;
   assign latch_if.raw = latch_pin;

   cglc_pin_sync u_gate_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     (gate_if)
   );
   cglc_pin_sync u_latch_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     (latch_if)
   );
   // Software-visible registers
   logic        [31:0] ctrl_q;
   logic        [31:0] cfg_q;
   logic signed [31:0] load_q;
   logic signed [31:0] end_q;
   logic signed [31:0] comp_q;
   logic        [31:0] param_q;
   logic        [31:0] rdata_q;
   // Channel state
   logic signed [31:0] count_q,  count_d;
   logic signed [31:0] latch_q;
   logic               latch_new_q;
   logic               software_gate_q;
   logic               igate_q,  igate_d;
   logic               auto_closed_q;
   logic               hw_seen_q;
   logic               last_up_q;
   logic               res_q,    res_d;
   logic               hyst_q,   hyst_d;
   logic signed [31:0] hyst_lo_q;
   logic signed [31:0] hyst_hi_q;
   logic               pulse_q;
   logic        [7:0]  steps_q;
   logic        [31:0] tick_q;
   logic               out_q;
   logic               event_q;

   function automatic logic signed [31:0] widen8(input logic [7:0] v);
      widen8 = signed'({24'h00_0000, v});
   endfunction : widen8
   // Bus decode
   wire wr_ctrl  = reg_wr && (reg_addr == cglc_pkg::ADDR_CTRL);
   wire wr_cfg   = reg_wr && (reg_addr == cglc_pkg::ADDR_CFG);
   wire wr_load  = reg_wr && (reg_addr == cglc_pkg::ADDR_LOAD);
   wire wr_end   = reg_wr && (reg_addr == cglc_pkg::ADDR_END);
   wire wr_comp  = reg_wr && (reg_addr == cglc_pkg::ADDR_COMP);
   wire wr_param = reg_wr && (reg_addr == cglc_pkg::ADDR_PARAM);
   // Output status word edges
   wire sw_open_edge  = wr_ctrl && reg_wdata[cglc_pkg::CTRL_SW_OPEN]
                        && !ctrl_q[cglc_pkg::CTRL_SW_OPEN];
   wire sw_close_edge = wr_ctrl && reg_wdata[cglc_pkg::CTRL_SW_CLOSE]
                        && !ctrl_q[cglc_pkg::CTRL_SW_CLOSE];
   wire latch_ack     = wr_ctrl && reg_wdata[cglc_pkg::CTRL_LATCH_SEL]
                        && !ctrl_q[cglc_pkg::CTRL_LATCH_SEL];
   wire latch_sel     = ctrl_q[cglc_pkg::CTRL_LATCH_SEL];

   // Configuration fields
   wire [4:0] gate_field = cfg_q[cglc_pkg::CFG_GATE_LSB +: cglc_pkg::CFG_GATE_W];
   wire       hw_en      = gate_field[cglc_pkg::GATE_HW_BIT];
   wire       gate_intr  = gate_field[cglc_pkg::GATE_INT_BIT];
   cglc_pkg::cglc_cmp_mode_t cmp_mode;
   cglc_pkg::cglc_dir_t      main_dir;
   assign cmp_mode = cglc_pkg::cglc_cmp_mode_t'(cfg_q[cglc_pkg::CFG_MODE_LSB +: 2]);
   assign main_dir = cglc_pkg::cglc_dir_t'(cfg_q[cglc_pkg::CFG_DIR_LSB +: 2]);
   wire       count_once = cfg_q[cglc_pkg::CFG_ONCE];
   wire       irq_en     = cfg_q[cglc_pkg::CFG_IRQ_EN];
   wire [7:0] pulse_dur  = param_q[cglc_pkg::PAR_DUR_LSB +: cglc_pkg::PAR_FIELD_W];
   wire [7:0] hyst_w     = param_q[cglc_pkg::PAR_HYST_LSB +: cglc_pkg::PAR_FIELD_W];

   // Gate sources
   wire hw_level   = hw_en ? gate_if.level : 1'b1;
   wire hw_rise    = hw_en && gate_if.rise;
   wire hw_fall    = hw_en && !gate_if.level && igate_q && !sw_open_edge;
   wire sw_rise    = sw_open_edge && !software_gate_q;
   wire sw_after   = (software_gate_q || sw_open_edge) && !sw_close_edge;
   // Opening conditions; after an automatic close with the hardware gate on, a hardware rise must come first
   wire open_by_hw = hw_rise && sw_after;
   wire open_by_sw = sw_rise && hw_level
                     && (!auto_closed_q || !hw_en || hw_seen_q);
   // Abort reload: software-only opens, or hardware opens in combined mode
   wire restart    = !gate_intr && ((open_by_sw && !hw_en) || open_by_hw);

   // Counting step
   wire step_up   = igate_q && cnt_up && !cnt_down;
   wire step_dn   = igate_q && cnt_down && !cnt_up;
   wire end_up    = (main_dir == cglc_pkg::DIR_UP) && step_up
                    && (count_q == end_q - cglc_pkg::CNT_ONE);
   wire end_dn    = (main_dir == cglc_pkg::DIR_DOWN) && step_dn
                    && (count_q == end_q + cglc_pkg::CNT_ONE);
   wire wrap_up   = step_up && (count_q == cglc_pkg::CNT_MAX);
   wire wrap_dn   = step_dn && (count_q == cglc_pkg::CNT_MIN);
   wire limit_hit = end_up || end_dn || wrap_up || wrap_dn;
   wire auto_close = count_once && limit_hit;

   always_comb begin
      count_d = count_q;
      if (restart) begin
         count_d = load_q;
      end else if (end_up || end_dn) begin
         count_d = load_q;
      end else if (wrap_up) begin
         count_d = cglc_pkg::CNT_MIN;
      end else if (wrap_dn) begin
         count_d = cglc_pkg::CNT_MAX;
      end else if (step_up) begin
         count_d = count_q + cglc_pkg::CNT_ONE;
      end else if (step_dn) begin
         count_d = count_q - cglc_pkg::CNT_ONE;
      end
   end

   always_comb begin
      igate_d = igate_q;
      if (sw_close_edge || hw_fall || auto_close) begin
         igate_d = 1'b0;
      end else if (open_by_hw || open_by_sw) begin
         igate_d = 1'b1;
      end else if (hw_rise) begin
         igate_d = sw_after;
      end
   end

   // Comparison condition before hysteresis
   wire dir_ok   = (main_dir == cglc_pkg::DIR_NONE)
                   || ((main_dir == cglc_pkg::DIR_UP) && last_up_q)
                   || ((main_dir == cglc_pkg::DIR_DOWN) && !last_up_q);
   wire cond_ge  = (count_q >= comp_q);
   wire cond_eq  = (count_q == comp_q) && dir_ok;
   wire cond_raw = (cmp_mode == cglc_pkg::CMP_GE) ? cond_ge : cond_eq;
   wire hyst_on  = (hyst_w > cglc_pkg::HYST_OFF_MAX);
   wire in_band  = (count_q >= hyst_lo_q) && (count_q <= hyst_hi_q);
   wire arm_band = !hyst_q && cond_raw && !res_q && hyst_on;

   always_comb begin
      res_d  = cond_raw;
      hyst_d = hyst_q;
      if (hyst_q) begin
         if (in_band) begin
            res_d = res_q;
         end else begin
            hyst_d = 1'b0;
         end
      end else if (arm_band) begin
         hyst_d = 1'b1;
      end
   end

   wire cmp_rise    = res_d && !res_q && (cmp_mode != cglc_pkg::CMP_NEVER);
   wire pulse_timed = (cmp_mode == cglc_pkg::CMP_PULSE) && (pulse_dur != 8'h00);
   wire pulse_start = pulse_timed && cmp_rise && !pulse_q;
   wire tick_end    = (tick_q == 32'(STEP_CYCLES - 1));
   wire pulse_last  = pulse_q && tick_end && (steps_q == 8'h01);

   logic out_d;
   always_comb begin
      case (cmp_mode)
         cglc_pkg::CMP_NEVER: out_d = ctrl_q[cglc_pkg::CTRL_DOUT];
         cglc_pkg::CMP_GE:    out_d = res_d;
         cglc_pkg::CMP_PULSE: out_d = pulse_timed ? ((pulse_q && !pulse_last) || pulse_start)
                                                  : res_d;
         default:             out_d = 1'b0;
      endcase
   end

   // Register file
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_q  <= cglc_pkg::RST_ZERO;
         cfg_q   <= cglc_pkg::RST_ZERO;
         load_q  <= cglc_pkg::RST_ZERO;
         end_q   <= cglc_pkg::RST_ZERO;
         comp_q  <= cglc_pkg::RST_ZERO;
         param_q <= cglc_pkg::RST_ZERO;
      end else begin
         if (wr_ctrl)  ctrl_q  <= reg_wdata & cglc_pkg::CTRL_MASK;
         if (wr_cfg)   cfg_q   <= reg_wdata & cglc_pkg::CFG_MASK;
         if (wr_load)  load_q  <= reg_wdata;
         if (wr_end)   end_q   <= reg_wdata;
         if (wr_comp)  comp_q  <= reg_wdata;
         if (wr_param) param_q <= reg_wdata & cglc_pkg::PARAM_MASK;
      end
   end

   // Gate and counter state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count_q       <= cglc_pkg::CNT_ONE - cglc_pkg::CNT_ONE;
         software_gate_q     <= 1'b0;
         igate_q       <= 1'b0;
         auto_closed_q <= 1'b0;
         hw_seen_q     <= 1'b0;
         last_up_q     <= 1'b1;
      end else begin
         count_q   <= count_d;
         software_gate_q <= sw_after;
         igate_q   <= igate_d;
         if (step_up || step_dn) last_up_q <= step_up;
         if (auto_close) begin
            auto_closed_q <= 1'b1;
            hw_seen_q     <= 1'b0;
         end else if (igate_d) begin
            auto_closed_q <= 1'b0;
         end else if (hw_rise) begin
            hw_seen_q <= 1'b1;
         end
      end
   end

   // Latch capture; a new capture wins over an acknowledge in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         latch_q     <= cglc_pkg::CNT_MIN ^ cglc_pkg::CNT_MIN;
         latch_new_q <= 1'b0;
      end else if (latch_if.rise && igate_q) begin
         latch_q     <= count_q;
         latch_new_q <= 1'b1;
      end else if (latch_ack) begin
         latch_new_q <= 1'b0;
      end
   end

   // Comparison, hysteresis band and pulse timer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         res_q     <= 1'b0;
         hyst_q    <= 1'b0;
         hyst_lo_q <= cglc_pkg::RST_ZERO;
         hyst_hi_q <= cglc_pkg::RST_ZERO;
         pulse_q   <= 1'b0;
         steps_q   <= 8'h00;
         tick_q    <= cglc_pkg::RST_ZERO;
         out_q     <= 1'b0;
         event_q   <= 1'b0;
      end else begin
         res_q  <= res_d;
         hyst_q <= hyst_d;
         // Band is latched at arming, so a later width change waits for the next one
         if (arm_band) begin
            hyst_lo_q <= comp_q - widen8(hyst_w);
            hyst_hi_q <= comp_q + widen8(hyst_w);
         end
         if (pulse_start) begin
            pulse_q <= 1'b1;
            steps_q <= pulse_dur;
            tick_q  <= cglc_pkg::RST_ZERO;
         end else if (pulse_q) begin
            tick_q <= tick_end ? cglc_pkg::RST_ZERO : tick_q + 32'h0000_0001;
            if (tick_end) begin
               steps_q <= steps_q - 8'h01;
               pulse_q <= !pulse_last;
            end
         end
         out_q   <= out_d;
         event_q <= cmp_rise && irq_en;
      end
   end
   // Read path, one cycle after the strobe
   wire [31:0] status_w = {16'h0000, latch_new_q, 9'h000, pulse_q, hyst_q, out_q,
                           hw_level, software_gate_q, igate_q};
   wire [31:0] data_w   = latch_sel ? latch_q : count_q;
   logic [31:0] rsel;
   always_comb begin
      case (reg_addr)
         cglc_pkg::ADDR_CTRL:   rsel = ctrl_q;
         cglc_pkg::ADDR_CFG:    rsel = cfg_q;
         cglc_pkg::ADDR_LOAD:   rsel = load_q;
         cglc_pkg::ADDR_END:    rsel = end_q;
         cglc_pkg::ADDR_COMP:   rsel = comp_q;
         cglc_pkg::ADDR_PARAM:  rsel = param_q;
         cglc_pkg::ADDR_STATUS: rsel = status_w;
         cglc_pkg::ADDR_DATA:   rsel = data_w;
         default:               rsel = cglc_pkg::RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= cglc_pkg::RST_ZERO;
      end else begin
         rdata_q <= reg_rd ? rsel : cglc_pkg::RST_ZERO;
      end
   end

   assign reg_rdata = rdata_q;
   assign cnt_out   = out_q;
   assign cmp_event = event_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_sw_open_gate: assert property (sw_rise && !hw_en && !sw_close_edge |=> igate_q)
      else $error("software open did not open gate");
   chk_sw_close_gate: assert property (sw_close_edge |=> !igate_q && !software_gate_q)
      else $error("software close did not close gate");
   chk_hw_blocks: assert property (sw_rise && hw_en && !hw_level && !hw_rise |=> !igate_q)
      else $error("software rise opened gate with hardware gate low");
   chk_abort_reload: assert property (restart |=> count_q == $past(load_q))
      else $error("abort reopen did not reload");
   chk_intr_resume: assert property (gate_intr && !igate_q && igate_d && !limit_hit
                                     |=> count_q == $past(count_q))
      else $error("interrupt reopen changed the count");
   chk_latch_copy: assert property (latch_if.rise && igate_q
                                    |=> latch_q == $past(count_q) && latch_new_q)
      else $error("latch value not captured");
   chk_latch_ack: assert property (latch_ack && !(latch_if.rise && igate_q) |=> !latch_new_q)
      else $error("latch flag not cleared");
   chk_ge_output: assert property (cmp_mode == cglc_pkg::CMP_GE && !hyst_q
                                   |=> cnt_out == $past(cond_ge))
      else $error("greater-or-equal output wrong");
   chk_no_retrig: assert property (pulse_q && cmp_rise |=> $stable(steps_q)
                                   || $past(tick_end))
      else $error("running pulse was retriggered");
   chk_band_freeze: assert property (hyst_q && in_band |=> res_q == $past(res_q))
      else $error("result changed inside hysteresis band");
   cov_latch: cover property (latch_if.rise && igate_q ##1 latch_ack);
   cov_pulse_end: cover property (pulse_last);
   cov_auto_reopen: cover property (auto_close ##[1:50] igate_q);
   cov_band_leave: cover property (hyst_q ##1 !hyst_q);
endmodule : cglc_top

// ---- tb/cglc_far_model.sv ----
// Far-side model: count pulses and the gate and latch pins
`timescale 1ns/10ps
module cglc_far_model (
   input  wire logic clk_sys,
   output logic      cnt_up,
   output logic      cnt_down,
   output logic      gate_pin,
   output logic      latch_pin
);
   initial begin
      cnt_up = 1'b0;
      cnt_down = 1'b0;
      gate_pin = 1'b0;
      latch_pin = 1'b0;
   end
   // Back to back steps, one per cycle
   task automatic step(input logic up, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         cnt_up   <= up;
         cnt_down <= ~up;
      end
      @(posedge clk_sys);
      cnt_up   <= 1'b0;
      cnt_down <= 1'b0;
   endtask : step
   // Held well past the synchroniser depth
   task automatic pins(input logic g, input logic l);
      @(posedge clk_sys);
      gate_pin  <= g;
      latch_pin <= l;
      repeat (8) @(posedge clk_sys);
   endtask : pins
endmodule : cglc_far_model

// ---- tb/tb.sv ----
// Self-checking bench for the counter gate, latch and compare block
`timescale 1ns/10ps
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] v;
   logic        cnt_up, cnt_down, gate_pin, latch_pin, cnt_out, cmp_event;
   int          mismatches = 0;
   int          checks = 0;
   int          ev_n = 0;
   int          hi_n = 0;
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (cmp_event === 1'b1) ev_n <= ev_n + 1;
      if (cnt_out === 1'b1) hi_n <= hi_n + 1;
   end
   // Short pulse step keeps the pulse scenario brief
   cglc_top #(.STEP_CYCLES(4)) i_cglc_top (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cnt_up(cnt_up), .cnt_down(cnt_down), .gate_pin(gate_pin),
      .latch_pin(latch_pin), .cnt_out(cnt_out), .cmp_event(cmp_event));
   cglc_far_model i_cglc_far_model (.clk_sys(clk_sys), .cnt_up(cnt_up),
      .cnt_down(cnt_down), .gate_pin(gate_pin), .latch_pin(latch_pin));
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wt
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(cglc_pkg::ADDR_STATUS);
      chk(v, 32'h0000_0004);
      rd(6'h20);
      chk(v, 32'h0000_0000);
      wr(cglc_pkg::ADDR_LOAD, 32'h0000_0010);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      wt(2);
      i_cglc_far_model.step(1'b1, 3);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0013);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0404);
      i_cglc_far_model.step(1'b1, 2);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0013);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      wt(2);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0010);
      i_cglc_far_model.step(1'b1, 5);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0010);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0400);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      wt(2);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0015);
      // Combined gate: software rise alone must not open
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0400);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0001);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      i_cglc_far_model.step(1'b1, 2);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0015);
      i_cglc_far_model.pins(1'b1, 1'b0);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0010);
      i_cglc_far_model.step(1'b1, 4);
      i_cglc_far_model.pins(1'b1, 1'b1);
      i_cglc_far_model.step(1'b1, 2);
      rd(cglc_pkg::ADDR_STATUS);
      chk({31'h0, v[cglc_pkg::STS_LATCH_NEW]}, 32'h0000_0001);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0104);
      rd(cglc_pkg::ADDR_DATA);
      chk(v, 32'h0000_0014);
      rd(cglc_pkg::ADDR_STATUS);
      chk({31'h0, v[cglc_pkg::STS_LATCH_NEW]}, 32'h0000_0000);
      i_cglc_far_model.pins(1'b1, 1'b0);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      wr(cglc_pkg::ADDR_COMP, 32'h0000_0018);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0421);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      i_cglc_far_model.step(1'b1, 2);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0001);
      chk(ev_n, 32'h0000_0001);
      i_cglc_far_model.step(1'b0, 1);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      // Leave and reach again inside the pulse: no stretch
      wr(cglc_pkg::ADDR_PARAM, 32'h0000_0002);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0041);
      wt(3);
      hi_n = 0;
      i_cglc_far_model.step(1'b1, 1);
      i_cglc_far_model.step(1'b0, 1);
      i_cglc_far_model.step(1'b1, 1);
      wt(20);
      chk(hi_n, 32'h0000_0008);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0001);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0005);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0001);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      // Hysteresis band of 3 around the comparison value
      i_cglc_far_model.step(1'b0, 2);
      wr(cglc_pkg::ADDR_PARAM, 32'h0000_0300);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0421);
      i_cglc_far_model.step(1'b1, 2);
      // Width change while the band is active must not shrink it
      wr(cglc_pkg::ADDR_PARAM, 32'h0000_0100);
      i_cglc_far_model.step(1'b0, 1);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0001);
      i_cglc_far_model.step(1'b1, 1);
      i_cglc_far_model.step(1'b0, 4);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      chk(ev_n, 32'h0000_0002);
      // Width 1 counts as off, so no band is armed
      i_cglc_far_model.step(1'b1, 4);
      i_cglc_far_model.step(1'b0, 1);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      chk(ev_n, 32'h0000_0003);
      // Zero-length pulse, main direction down
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0141);
      i_cglc_far_model.step(1'b1, 1);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0000);
      i_cglc_far_model.step(1'b1, 1);
      i_cglc_far_model.step(1'b0, 1);
      wt(3);
      chk({31'h0, cnt_out}, 32'h0000_0001);
      // Count once: end value closes the gate, reopen needs a hardware rise
      wr(cglc_pkg::ADDR_END, 32'h0000_001a);
      wr(cglc_pkg::ADDR_CFG, 32'h0000_0281);
      i_cglc_far_model.step(1'b1, 2);
      rd(cglc_pkg::ADDR_STATUS);
      chk({31'h0, v[cglc_pkg::STS_IGATE]}, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0400);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      rd(cglc_pkg::ADDR_STATUS);
      chk({31'h0, v[cglc_pkg::STS_IGATE]}, 32'h0000_0000);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0400);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0000);
      i_cglc_far_model.pins(1'b0, 1'b0);
      i_cglc_far_model.pins(1'b1, 1'b0);
      wr(cglc_pkg::ADDR_CTRL, 32'h0000_0004);
      rd(cglc_pkg::ADDR_STATUS);
      chk({31'h0, v[cglc_pkg::STS_IGATE]}, 32'h0000_0001);
      stop_test();
   end
endmodule : tb
